// File: src/perf_mon_pkg.sv
// Constants, types and register map of the T1 alarm and performance monitor
// Operation
// - Self-clearing on: alarm drops after condition absent for duration period.
// - Self-clearing off: alarm stays until clear-alarm command.
// - Line processing and yellow alarm stop once condition disappears.
// - Bit errors raise level 1 or 2; other conditions always level 2.
// - Two of four framing bits errored: out-of-frame, reframe, silence.
// - 192 consecutive zeros: loss of signal, then resynchronize.
// - Loss of signal over two seconds: level 2 alarm and silence.
// - Loss-of-signal or AIS alarm clears after the duration period, but no less than two quiet seconds.
// - Unframed all ones is AIS; over two seconds: level 2, silence.
// - Alarm disable: contact off, maintenance LED on, no yellow or processing.
// - Alarm enable restores contact, yellow alarm and line processing.
// - Clear alarm: contact open, LED off, log clear, redeclare if present.
// - Keep latest 100 stamped alarm events; clear-log command erases all.
// - Status gives alarm state, level and hook state of 24 ports.
// - Sample criteria each second, count an hour, keep 24 hours.
// - Errored second: any CRC error or out-of-frame event.
// - Bursty second: CRC errors above one and below 320.
// - Severely errored: over 320 CRC errors or out-of-frame event.
// - Unavailable after 10 severe seconds; ends after 10 non-severe, excluded.
// - Loss-of-frame second after three such seconds; one slip second per second with any slip.
// - Overall error counter sums criteria, saturates, clears by command.
// - Hourly, counts copied to history then zeroed; error counter kept.
// - Level 2: contact, LED, log, line processing, yellow alarm.
package perf_mon_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int SECOND_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SECOND_S;
    localparam int LOS_BITS = 192;
    localparam int OOF_ERRS = 2;
    localparam int LOS_HOLD_S = 2;
    localparam int QUIET_S = 2;
    localparam int HOUR_S = 3600;
    localparam int HIST_DEPTH = 24;
    localparam int LOG_DEPTH = 100;
    localparam int BURST_LIM = 320;
    localparam int UAS_RUN = 10;
    localparam int LOF_RUN = 3;
    localparam int ERR_MAX = 65000;
    localparam int PORTS = 24;
    localparam logic [11:0] DUR_RESET = 12'h00A;
    localparam logic SELF_CLEAR_RESET = 1'b1;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DUR = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_HOOK = 8'h10;
    localparam logic [7:0] OFF_ERRCNT = 8'h14;
    localparam logic [7:0] OFF_PERF_A = 8'h18;
    localparam logic [7:0] OFF_PERF_B = 8'h1C;
    localparam logic [7:0] OFF_PERF_C = 8'h20;
    localparam logic [7:0] OFF_LOG_SEL = 8'h24;
    localparam logic [7:0] OFF_LOG_DATA = 8'h28;
    localparam logic [7:0] OFF_LOG_COUNT = 8'h2C;
    localparam logic [7:0] OFF_HIST_SEL = 8'h30;
    localparam logic [7:0] OFF_HIST_A = 8'h34;
    localparam logic [7:0] OFF_HIST_B = 8'h38;
    localparam logic [7:0] OFF_HIST_C = 8'h3C;
    localparam int CMD_CLR_ALARM = 0;
    localparam int CMD_DISABLE = 1;
    localparam int CMD_ENABLE = 2;
    localparam int CMD_CLR_LOG = 3;
    localparam int CMD_CLR_ERR = 4;
    typedef enum logic [1:0] {
        NO_ALARM = 2'b00,
        MINOR_ALARM_LEVEL = 2'b01,
        MAJOR_ALARM_LEVEL = 2'b10
    } alarm_level_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic [3:0] code;
        logic [27:0] stamp;
    } log_entry_t;
    typedef struct packed {
        logic [11:0] es;
        logic [11:0] bs;
        logic [11:0] uas;
        logic [11:0] lofs;
        logic [11:0] fss;
    } perf_t;
endpackage

// File: src/t1_alarm_perf_monitor.sv
// T1 alarm supervision, alarm log and performance counters
`timescale 1ns/100ps
module t1_alarm_perf_monitor #(
    parameter int TICK_CYCLES = perf_mon_pkg::SEC_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input perf_mon_pkg::reg_req_t BUS_REQ,
    output logic [31:0] BUS_RDATA,
    input wire logic RX_BIT_VALID,
    input wire logic RX_BIT,
    input wire logic FBIT_VALID,
    input wire logic FBIT_ERR,
    input wire logic REFRAME_DONE,
    input wire logic CRC_ERR,
    input wire logic SLIP,
    input wire logic BER_MINOR,
    input wire logic BER_MAJOR,
    input wire logic SLIP_ALARM,
    input wire logic [23:0] HOOK,
    input wire logic [27:0] TIME_STAMP,
    output logic REFRAME_REQ,
    output logic RESYNC_REQ,
    output logic RX_SILENCE,
    output logic ALARM_CONTACT,
    output logic ALARM_LED,
    output logic MAINTENANCE_INDICATOR,
    output logic YELLOW_TX,
    output logic LINE_PROC
);
    import perf_mon_pkg::*;
    localparam int TW = $clog2(TICK_CYCLES);

    function automatic logic [11:0] sat12(input logic [11:0] v);
        sat12 = (v == 12'hFFF) ? v : v + 12'h001;
    endfunction

    // Register bus
    logic wr_cmd;
    logic [4:0] cmd;
    logic self_clear;
    logic [11:0] duration;
    logic enabled;
    logic [6:0] log_sel;
    logic [4:0] hist_sel;
    assign wr_cmd = BUS_REQ.wr && BUS_REQ.addr == OFF_CMD;
    assign cmd = wr_cmd ? BUS_REQ.wdata[4:0] : 5'h00;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            self_clear <= SELF_CLEAR_RESET;
            duration <= DUR_RESET;
            log_sel <= 7'h00;
            hist_sel <= 5'h00;
        end else if (BUS_REQ.wr) begin
            case (BUS_REQ.addr)
                OFF_CTRL: self_clear <= BUS_REQ.wdata[0];
                OFF_DUR: duration <= BUS_REQ.wdata[11:0];
                OFF_LOG_SEL: log_sel <= BUS_REQ.wdata[6:0];
                OFF_HIST_SEL: hist_sel <= BUS_REQ.wdata[4:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            enabled <= 1'b1;
        end else if (cmd[CMD_DISABLE]) begin
            enabled <= 1'b0;
        end else if (cmd[CMD_ENABLE]) begin
            enabled <= 1'b1;
        end
    end

    // One-second tick from the card clock
    logic [TW-1:0] tick_cnt;
    logic tick;
    assign tick = tick_cnt == TW'(TICK_CYCLES - 1);
    always_ff @(posedge CLK_SYS) begin
        if (RESET || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // Out-of-frame detection over the last four framing bits
    logic [2:0] fwin;
    logic oof;
    logic oof_declare;
    assign oof_declare = !oof && FBIT_VALID && FBIT_ERR
        && ($countones(fwin) >= OOF_ERRS - 1);
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            fwin <= 3'h0;
            oof <= 1'b0;
            REFRAME_REQ <= 1'b0;
        end else begin
            if (FBIT_VALID) begin
                fwin <= oof ? 3'h0 : {fwin[1:0], FBIT_ERR};
            end
            if (oof_declare) begin
                oof <= 1'b1;
            end else if (REFRAME_DONE) begin
                oof <= 1'b0;
            end
            REFRAME_REQ <= oof_declare;
        end
    end

    // Loss of signal and AIS from runs of equal receive bits
    logic [7:0] zero_run;
    logic [7:0] one_run;
    logic los;
    logic ais;
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            zero_run <= 8'h00;
            one_run <= 8'h00;
            los <= 1'b0;
            RESYNC_REQ <= 1'b0;
        end else begin
            RESYNC_REQ <= 1'b0;
            if (RX_BIT_VALID) begin
                zero_run <= RX_BIT ? 8'h00
                    : (zero_run == 8'(LOS_BITS) ? zero_run : zero_run + 8'h01);
                one_run <= !RX_BIT ? 8'h00
                    : (one_run == 8'(LOS_BITS) ? one_run : one_run + 8'h01);
                if (!RX_BIT && zero_run == 8'(LOS_BITS - 1)) begin
                    los <= 1'b1;
                    RESYNC_REQ <= 1'b1;
                end else if (RX_BIT) begin
                    los <= 1'b0;
                end
            end
        end
    end
    assign ais = oof && one_run == 8'(LOS_BITS);

    // Persistence of loss of signal and AIS in seconds
    logic [1:0] los_sec;
    logic [1:0] ais_sec;
    logic los_long;
    logic ais_long;
    assign los_long = los && los_sec > 2'(LOS_HOLD_S);
    assign ais_long = ais && ais_sec > 2'(LOS_HOLD_S);
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            los_sec <= 2'h0;
            ais_sec <= 2'h0;
        end else begin
            if (!los) begin
                los_sec <= 2'h0;
            end else if (tick && los_sec != 2'h3) begin
                los_sec <= los_sec + 2'h1;
            end
            if (!ais) begin
                ais_sec <= 2'h0;
            end else if (tick && ais_sec != 2'h3) begin
                ais_sec <= ais_sec + 2'h1;
            end
        end
    end

    // Alarm level state
    alarm_level_t level;
    alarm_level_t next_level;
    logic cond_major;
    logic cond_any;
    logic cause_la;
    logic [11:0] quiet;
    logic [11:0] need;
    assign cond_major = BER_MAJOR || SLIP_ALARM || oof
        || los_long || ais_long;
    assign cond_any = cond_major || BER_MINOR || los || ais;
    assign need = (cause_la && duration < 12'(QUIET_S))
        ? 12'(QUIET_S) : duration;

    always_comb begin
        next_level = level;
        case (level)
            NO_ALARM: begin
                if (cond_major) begin
                    next_level = MAJOR_ALARM_LEVEL;
                end else if (BER_MINOR) begin
                    next_level = MINOR_ALARM_LEVEL;
                end
            end
            MINOR_ALARM_LEVEL, MAJOR_ALARM_LEVEL: begin
                if (cmd[CMD_CLR_ALARM]) begin
                    next_level = NO_ALARM;
                end else if (cond_major) begin
                    next_level = MAJOR_ALARM_LEVEL;
                end else if (self_clear && quiet >= need) begin
                    next_level = NO_ALARM;
                end
            end
            default: next_level = NO_ALARM;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            level <= NO_ALARM;
            cause_la <= 1'b0;
            quiet <= 12'h000;
        end else begin
            level <= next_level;
            if (los_long || ais_long) begin
                cause_la <= 1'b1;
            end else if (next_level == NO_ALARM) begin
                cause_la <= 1'b0;
            end
            if (cond_any || level == NO_ALARM) begin
                quiet <= 12'h000;
            end else if (tick) begin
                quiet <= sat12(quiet);
            end
        end
    end

    // Indications toward the contact, LEDs and far end
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ALARM_CONTACT <= 1'b0;
            ALARM_LED <= 1'b0;
            MAINTENANCE_INDICATOR <= 1'b0;
            YELLOW_TX <= 1'b0;
            LINE_PROC <= 1'b0;
            RX_SILENCE <= 1'b0;
        end else begin
            ALARM_CONTACT <= enabled && level != NO_ALARM;
            ALARM_LED <= level != NO_ALARM;
            MAINTENANCE_INDICATOR <= !enabled;
            YELLOW_TX <= enabled && cond_major
                && level == MAJOR_ALARM_LEVEL;
            LINE_PROC <= enabled && cond_major
                && level == MAJOR_ALARM_LEVEL;
            RX_SILENCE <= oof || los_long || ais_long;
        end
    end

    // Alarm log, newest entry read first
    log_entry_t log_mem [0:LOG_DEPTH-1];
    logic [6:0] log_ptr;
    logic [6:0] log_count;
    logic [7:0] log_pos;
    logic [6:0] log_idx;
    log_entry_t log_rd;
    assign log_pos = {1'b0, log_ptr} + 8'(LOG_DEPTH - 1) - {1'b0, log_sel};
    assign log_idx = (log_pos >= 8'(LOG_DEPTH))
        ? 7'(log_pos - 8'(LOG_DEPTH)) : log_pos[6:0];
    assign log_rd = (log_sel < log_count) ? log_mem[log_idx] : '0;

    always_ff @(posedge CLK_SYS) begin
        if (RESET || cmd[CMD_CLR_LOG]) begin
            log_ptr <= 7'h00;
            log_count <= 7'h00;
        end else if (next_level != level) begin
            log_ptr <= (log_ptr == 7'(LOG_DEPTH - 1))
                ? 7'h00 : log_ptr + 7'h01;
            if (log_count != 7'(LOG_DEPTH)) begin
                log_count <= log_count + 7'h01;
            end
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (next_level != level) begin
            log_mem[log_ptr] <= '{code: {2'b00, next_level},
                                  stamp: TIME_STAMP};
        end
    end

    // Per-second accumulation
    logic [8:0] crc_sec;
    logic oof_sec;
    logic slip_sec;
    logic lof_sec;
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            crc_sec <= 9'h000;
            oof_sec <= 1'b0;
            slip_sec <= 1'b0;
            lof_sec <= 1'b0;
        end else if (tick) begin
            // Events on the tick edge open the next second
            crc_sec <= {8'h00, CRC_ERR};
            oof_sec <= oof_declare;
            slip_sec <= SLIP;
            lof_sec <= oof || los;
        end else begin
            if (CRC_ERR && crc_sec != 9'h1FF) begin
                crc_sec <= crc_sec + 9'h001;
            end
            oof_sec <= oof_sec || oof_declare;
            slip_sec <= slip_sec || SLIP;
            lof_sec <= lof_sec || oof || los;
        end
    end

    logic es;
    logic bs;
    logic ses;
    assign es = crc_sec != 9'h000 || oof_sec;
    assign bs = crc_sec > 9'h001 && crc_sec < 9'(BURST_LIM);
    assign ses = crc_sec > 9'(BURST_LIM) || oof_sec;

    // Unavailable state and loss-of-frame runs
    logic unavail;
    logic next_unavail;
    logic [3:0] ses_run;
    logic [3:0] next_ses_run;
    logic [3:0] pend;
    logic [3:0] next_pend;
    logic [3:0] uas_add;
    logic [1:0] lof_run;
    logic lofs;
    assign lofs = lof_sec && lof_run >= 2'(LOF_RUN - 1);

    always_comb begin
        next_unavail = unavail;
        next_ses_run = ses_run;
        next_pend = pend;
        uas_add = 4'h0;
        if (!unavail) begin
            next_ses_run = ses ? ses_run + 4'h1 : 4'h0;
            if (ses && ses_run == 4'(UAS_RUN - 1)) begin
                next_unavail = 1'b1;
                next_ses_run = 4'h0;
                uas_add = 4'(UAS_RUN);
            end
        end else if (ses) begin
            uas_add = pend + 4'h1;
            next_pend = 4'h0;
        end else if (pend == 4'(UAS_RUN - 1)) begin
            next_unavail = 1'b0;
            next_pend = 4'h0;
        end else begin
            next_pend = pend + 4'h1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            unavail <= 1'b0;
            ses_run <= 4'h0;
            pend <= 4'h0;
            lof_run <= 2'h0;
        end else if (tick) begin
            unavail <= next_unavail;
            ses_run <= next_ses_run;
            pend <= next_pend;
            if (!lof_sec) begin
                lof_run <= 2'h0;
            end else if (lof_run != 2'h3) begin
                lof_run <= lof_run + 2'h1;
            end
        end
    end

    // Hourly counters, history and overall error counter
    perf_t perf;
    perf_t next_perf;
    perf_t hist [0:HIST_DEPTH-1];
    logic [4:0] hist_ptr;
    logic [11:0] sec_cnt;
    logic hour_end;
    logic [15:0] err_cnt;
    logic [16:0] err_sum;
    assign hour_end = tick && sec_cnt == 12'(HOUR_S - 1);
    assign err_sum = {1'b0, err_cnt} + 17'(es) + 17'(bs) + 17'(uas_add)
        + 17'(lofs) + 17'(slip_sec);

    always_comb begin
        next_perf = perf;
        if (es) next_perf.es = sat12(perf.es);
        if (bs) next_perf.bs = sat12(perf.bs);
        next_perf.uas = perf.uas + 12'(uas_add);
        if (lofs) next_perf.lofs = sat12(perf.lofs);
        if (slip_sec) next_perf.fss = sat12(perf.fss);
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            perf <= '0;
            sec_cnt <= 12'h000;
            hist_ptr <= 5'h00;
        end else if (hour_end) begin
            perf <= '0;
            sec_cnt <= 12'h000;
            hist_ptr <= (hist_ptr == 5'(HIST_DEPTH - 1))
                ? 5'h00 : hist_ptr + 5'h01;
        end else if (tick) begin
            perf <= next_perf;
            sec_cnt <= sec_cnt + 12'h001;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (hour_end) begin
            hist[hist_ptr] <= next_perf;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET || cmd[CMD_CLR_ERR]) begin
            err_cnt <= 16'h0000;
        end else if (tick) begin
            err_cnt <= (err_sum > 17'(ERR_MAX))
                ? 16'(ERR_MAX) : err_sum[15:0];
        end
    end

    // Read data, one cycle after the strobe
    perf_t hist_rd;
    logic [31:0] rmux;
    assign hist_rd = (hist_sel < 5'(HIST_DEPTH)) ? hist[hist_sel] : '0;
    always_comb begin
        case (BUS_REQ.addr)
            OFF_CTRL: rmux = {31'h0, self_clear};
            OFF_DUR: rmux = {20'h0, duration};
            OFF_STATUS: rmux = {24'h0, unavail, ais, los, oof, enabled,
                                level != NO_ALARM, level};
            OFF_HOOK: rmux = {8'h0, HOOK};
            OFF_ERRCNT: rmux = {16'h0, err_cnt};
            OFF_PERF_A: rmux = {4'h0, perf.bs, 4'h0, perf.es};
            OFF_PERF_B: rmux = {4'h0, perf.lofs, 4'h0, perf.uas};
            OFF_PERF_C: rmux = {20'h0, perf.fss};
            OFF_LOG_SEL: rmux = {25'h0, log_sel};
            OFF_LOG_DATA: rmux = log_rd;
            OFF_LOG_COUNT: rmux = {25'h0, log_count};
            OFF_HIST_SEL: rmux = {27'h0, hist_sel};
            OFF_HIST_A: rmux = {4'h0, hist_rd.bs, 4'h0, hist_rd.es};
            OFF_HIST_B: rmux = {4'h0, hist_rd.lofs, 4'h0, hist_rd.uas};
            OFF_HIST_C: rmux = {20'h0, hist_rd.fss};
            default: rmux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            BUS_RDATA <= 32'h0000_0000;
        end else begin
            BUS_RDATA <= BUS_REQ.rd ? rmux : 32'h0000_0000;
        end
    end

    // Checks
    a_oof_declare: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!oof && FBIT_VALID && FBIT_ERR && fwin != 3'h0) |=> oof)
        else $error("out-of-frame not declared");
    a_los_declare: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (RX_BIT_VALID && !RX_BIT && zero_run == 8'(LOS_BITS - 1))
        |=> (los && RESYNC_REQ))
        else $error("loss of signal not declared");
    a_silence_oof: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (oof && $past(oof)) |=> RX_SILENCE)
        else $error("no silence while reframing");
    a_yellow_stop: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !cond_major |=> (!YELLOW_TX && !LINE_PROC))
        else $error("yellow or line processing outlived condition");
    a_disable_mode: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!enabled && level != NO_ALARM) |=>
        (!ALARM_CONTACT && !YELLOW_TX && MAINTENANCE_INDICATOR && ALARM_LED))
        else $error("alarm disable not honoured");
    a_major_raise: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (cond_major && !cmd[CMD_CLR_ALARM]) |=> level == MAJOR_ALARM_LEVEL)
        else $error("major condition did not raise level 2");
    a_hold_manual: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!self_clear && level != NO_ALARM && !cmd[CMD_CLR_ALARM])
        |=> level != NO_ALARM)
        else $error("alarm dropped without clear command");
    a_err_sat: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (tick && !cmd[CMD_CLR_ERR] && err_cnt == 16'(ERR_MAX))
        |=> err_cnt == 16'(ERR_MAX))
        else $error("error counter left saturation");
    a_hour_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
        hour_end |=> (perf == '0 && hist_ptr != $past(hist_ptr)))
        else $error("hourly reset missed");
    a_log_clear: assert property (@(posedge CLK_SYS) disable iff (RESET)
        cmd[CMD_CLR_LOG] |=> log_count == 7'h00 ##1 log_count <= 7'h01)
        else $error("alarm log not erased");
endmodule

// File: bench/t1_link_model.sv
// Far-end T1 link source: line bits and framing bits
`timescale 1ns/100ps
module t1_link_model (
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire logic fbit_bad,
    output logic bit_valid,
    output logic rx_bit,
    output logic fbit_valid,
    output logic fbit_err
);
    logic [2:0] phase;
    initial begin
        phase = 3'h0;
        bit_valid = 1'h0;
        rx_bit = 1'h0;
        fbit_valid = 1'h0;
        fbit_err = 1'h0;
    end
    // Mode 0 alternating data, 1 all zeros, 2 all ones
    always @(posedge clk) begin
        phase <= phase + 3'h1;
        bit_valid <= 1'h1;
        rx_bit <= (mode == 2'h0) ? ~rx_bit : (mode == 2'h2);
        fbit_valid <= (phase == 3'h7);
        // Error line toggles between framing bits
        fbit_err <= (phase == 3'h7) ? fbit_bad : ~fbit_err;
    end
endmodule

// File: bench/t1_alarm_performance_monitor_tb_top.sv
// Directed tests of the T1 alarm and performance monitor
`timescale 1ns/100ps
module t1_alarm_performance_monitor_tb_top;
    import perf_mon_pkg::*;
    localparam int TK = 20;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clk = 1'h0;
    logic rst = 1'h1;
    reg_req_t req = '0;
    logic [31:0] rdata;
    logic rv, rb, fv, fe, rfq, rsq, sil, con, led, mnt, yel, lpr;
    logic rfd = 1'h0, crc = 1'h0, bmin = 1'h0, bad = 1'h0;
    logic [1:0] mode = 2'h0;
    int num_errors = 0;
    int compares = 0;
    int cnt = 0;
    int i;
    always #12.5 clk = ~clk;
    t1_link_model LINK (.clk(clk), .mode(mode), .fbit_bad(bad),
        .bit_valid(rv), .rx_bit(rb), .fbit_valid(fv), .fbit_err(fe));
    t1_alarm_perf_monitor #(.TICK_CYCLES(TK)) DUT (.CLK_SYS(clk),
        .RESET(rst), .BUS_REQ(req), .BUS_RDATA(rdata),
        .RX_BIT_VALID(rv), .RX_BIT(rb), .FBIT_VALID(fv), .FBIT_ERR(fe),
        .REFRAME_DONE(rfd), .CRC_ERR(crc), .SLIP(1'h0),
        .BER_MINOR(bmin), .BER_MAJOR(1'h0), .SLIP_ALARM(1'h0),
        .HOOK(24'hA5C3F0), .TIME_STAMP(28'h1234567),
        .REFRAME_REQ(rfq), .RESYNC_REQ(rsq), .RX_SILENCE(sil),
        .ALARM_CONTACT(con), .ALARM_LED(led),
        .MAINTENANCE_INDICATOR(mnt), .YELLOW_TX(yel), .LINE_PROC(lpr));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
        @(posedge clk);
        req <= '0;
        #1 chk(n, e, rdata & m);
    endtask
    task automatic pulse_crc;
        @(posedge clk);
        crc <= 1'h1;
        @(posedge clk);
        crc <= 1'h0;
    endtask
    task automatic summarize;
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cnt <= cnt + 1;
        if (cnt == 80000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rd("ctrl", OFF_CTRL, ALL, 32'h1);
        rd("dur", OFF_DUR, ALL, 32'hA);
        rd("status", OFF_STATUS, ALL, 32'h8);
        rd("hook", OFF_HOOK, ALL, 32'hA5C3F0);
        rd("unmapped", 8'hFC, ALL, 32'h0);
        wr(OFF_CMD, 32'h8);
        rd("log count", OFF_LOG_COUNT, ALL, 32'h0);
        wr(OFF_CMD, 32'h2);
        cyc(2);
        chk("maintenance_indicator", 32'h1, 32'(mnt));
        rd("enabled", OFF_STATUS, 32'h8, 32'h0);
        wr(OFF_CMD, 32'h4);
        cyc(2);
        chk("maintenance_indicator", 32'h0, 32'(mnt));
        @(posedge clk) bmin <= 1'h1;
        cyc(4);
        rd("level", OFF_STATUS, 32'h3, 32'h1);
        chk("contact", 32'h1, 32'(con));
        chk("yellow", 32'h0, 32'(yel));
        wr(OFF_DUR, 32'h2);
        @(posedge clk) bmin <= 1'h0;
        cyc(6 * TK);
        chk("led", 32'h0, 32'(led));
        wr(OFF_CTRL, 32'h0);
        @(posedge clk) mode <= 2'h1;
        for (i = 0; i < 400 && rsq !== 1'h1; i++) cyc(1);
        chk("resync", 32'h1, 32'(rsq));
        cyc(4 * TK);
        chk("yellow", 32'h1, 32'(yel));
        chk("silence", 32'h1, 32'(sil));
        chk("contact", 32'h1, 32'(con));
        chk("line proc", 32'h1, 32'(lpr));
        rd("status", OFF_STATUS, 32'hF, 32'hE);
        @(posedge clk) mode <= 2'h0;
        cyc(5);
        chk("yellow", 32'h0, 32'(yel));
        chk("line proc", 32'h0, 32'(lpr));
        cyc(5 * TK);
        chk("led", 32'h1, 32'(led));
        wr(OFF_CMD, 32'h1);
        cyc(3);
        chk("led", 32'h0, 32'(led));
        chk("contact", 32'h0, 32'(con));
        rd("log count", OFF_LOG_COUNT, ALL, 32'h4);
        rd("log newest", OFF_LOG_DATA, ALL, 32'h01234567);
        @(posedge clk) bad <= 1'h1;
        for (i = 0; i < 100 && rfq !== 1'h1; i++) cyc(1);
        chk("reframe", 32'h1, 32'(rfq));
        cyc(1);
        chk("silence", 32'h1, 32'(sil));
        @(posedge clk) bad <= 1'h0;
        rd("level", OFF_STATUS, 32'h3, 32'h2);
        @(posedge clk) rfd <= 1'h1;
        @(posedge clk) rfd <= 1'h0;
        wr(OFF_CMD, 32'h1);
        cyc(2 * TK);
        // Unframed all ones, then recovery with a one-second duration
        wr(OFF_CTRL, 32'h1);
        wr(OFF_DUR, 32'h1);
        @(posedge clk);
        mode <= 2'h2;
        bad <= 1'h1;
        cyc(14 * TK);
        rd("ais", OFF_STATUS, 32'h70, 32'h50);
        chk("silence", 32'h1, 32'(sil));
        rd("level", OFF_STATUS, 32'h3, 32'h2);
        @(posedge clk);
        mode <= 2'h0;
        bad <= 1'h0;
        @(posedge clk) rfd <= 1'h1;
        @(posedge clk) rfd <= 1'h0;
        cyc(22);
        chk("led", 32'h1, 32'(led));
        cyc(21);
        chk("led", 32'h0, 32'(led));
        wr(OFF_CMD, 32'h10);
        rd("errcnt", OFF_ERRCNT, ALL, 32'h0);
        pulse_crc();
        cyc(2 * TK);
        rd("errcnt", OFF_ERRCNT, ALL, 32'h1);
        pulse_crc();
        pulse_crc();
        cyc(2 * TK);
        rd("errcnt", OFF_ERRCNT, ALL, 32'h3);
        cyc(3600 * TK);
        rd("perf a", OFF_PERF_A, ALL, 32'h0);
        rd("perf b", OFF_PERF_B, ALL, 32'h0);
        rd("errcnt", OFF_ERRCNT, ALL, 32'h3);
        summarize();
    end
endmodule
